// File: psd_pkg.sv
package psd_pkg;

  // ------------------------------------------------------------
  // serial word layout
  // ------------------------------------------------------------
  localparam int SR_W = 18;
  localparam int ADDR_BIT = 0;
  localparam int DATA_LSB = 1;
  localparam int DATA_W = 17;

  // register addresses carried in the address bit
  localparam logic REG_FEEDBACK = 1'b0;
  localparam logic REG_REFERENCE = 1'b1;

  // ------------------------------------------------------------
  // reference_divider_config fields
  // ------------------------------------------------------------
  localparam int REF_W = 14;
  localparam int RATIO_LSB = 0;
  localparam int RATIO_W = 10;
  localparam int FLOAT_BIT = 10;
  localparam int SENSE_BIT = 11;
  localparam int RSVD_BIT = 12;
  localparam int TEST_BIT = 13;
  localparam logic [REF_W-1:0] REF_RESET = 14'h0000;

  // ------------------------------------------------------------
  // feedback_divider_config fields
  // ------------------------------------------------------------
  localparam int FB_W = 17;
  localparam int SLEEP_BIT = 0;
  localparam int CLEAR_BIT = 1;
  localparam int CTL_LSB = 0;
  localparam int CTL_W = 2;
  localparam int SWALLOW_LSB = 2;
  localparam int SWALLOW_W = 5;
  localparam int MAIN_LSB = 7;
  localparam int MAIN_W = 10;
  localparam logic [FB_W-1:0] FB_RESET = 17'h00000;

  // counter constants
  localparam logic [RATIO_W-1:0] RATIO_ONE = 10'h001;
  localparam logic [RATIO_W-1:0] RATIO_ZERO = 10'h000;
  localparam logic [MAIN_W-1:0] MAIN_ONE = 10'h001;
  localparam logic [MAIN_W-1:0] MAIN_ZERO = 10'h000;

  // reference input ceiling, for information on the sampling margin
  localparam int REF_IN_MAX_MHZ = 40;

  // control pair decode
  typedef enum logic [1:0] {
    CTL_RUN = 2'b00,
    CTL_SYNC_SLEEP = 2'b01,
    CTL_CLEAR = 2'b10,
    CTL_ASYNC_SLEEP = 2'b11
  } psd_ctl_t;

endpackage

// File: psd_sync3.sv
`timescale 1ns/1ps
`default_nettype none

// three-stage synchroniser for a pin; a change is taken only once the
// second and third stages agree, so a single metastable sample is ignored
module psd_sync3 (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic pin,
  output logic level,
  output logic rise
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  // -----------------------------------------------------------
  // sampling chain
  // -----------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // filtered level follows only when stages two and three agree
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      level_r <= 1'b0;
    end else if (s2_r == s3_r) begin
      level_r <= s3_r;
    end
  end

  assign level = level_r;
  assign rise = (s2_r & s3_r) & ~level_r;

endmodule

`default_nettype wire

// File: psd_top.sv
`timescale 1ns/1ps
`default_nettype none

module psd_top (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic latch_strobe,
  input wire logic chip_enable,
  input wire logic reference_input,
  input wire logic rf_input,
  output logic modulus_sel,
  output logic pump_output,
  output logic pump_output_oe,
  output logic ref_osc_en,
  output logic rf_bias_en,
  output logic sleep_status,
  output logic [psd_pkg::FB_W-1:0] feedback_divider_config,
  output logic [psd_pkg::REF_W-1:0] reference_divider_config
);
  import psd_pkg::*;

  // ------------------------------------------------------------
  // serial link domain
  // ------------------------------------------------------------
  logic [SR_W-1:0] shift_r;

  // no power gating here: the host may reprogram while asleep
  always_ff @(posedge ser_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_r <= '0;
    end else begin
      shift_r <= {shift_r[SR_W-2:0], ser_data};
    end
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic strobe_rise, ce_lvl, ref_rise, rf_rise;

  psd_sync3 u_sync_strobe (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin(latch_strobe),
    .level(),
    .rise(strobe_rise)
  );

  psd_sync3 u_sync_ce (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin(chip_enable),
    .level(ce_lvl),
    .rise()
  );

  // reference input sampled at 100 MHz; fine for inputs up to 25 MHz
  psd_sync3 u_sync_ref (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin(reference_input),
    .level(),
    .rise(ref_rise)
  );

  psd_sync3 u_sync_rf (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin(rf_input),
    .level(),
    .rise(rf_rise)
  );

  // ------------------------------------------------------------
  // latch transfer
  // ------------------------------------------------------------
  // the shift register is quiet while the strobe is high (serial clock
  // stands still), so the word is stable when the strobe edge arrives
  logic [REF_W-1:0] ref_cfg_r;
  logic [FB_W-1:0] fb_cfg_r;
  wire [DATA_W-1:0] sr_data = shift_r[DATA_LSB +: DATA_W];
  wire sr_addr = shift_r[ADDR_BIT];
  wire load_ref = strobe_rise & (sr_addr == REG_REFERENCE);
  wire load_fb = strobe_rise & (sr_addr == REG_FEEDBACK);

  // each register only moves on its own address
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ref_cfg_r <= REF_RESET;
      fb_cfg_r <= FB_RESET;
    end else begin
      if (load_ref) begin
        ref_cfg_r <= sr_data[REF_W-1:0];
      end
      if (load_fb) begin
        fb_cfg_r <= sr_data;
      end
    end
  end

  // ------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------
  wire [RATIO_W-1:0] ref_ratio = ref_cfg_r[RATIO_LSB +: RATIO_W];
  wire pump_float = ref_cfg_r[FLOAT_BIT];
  wire sense_pos = ref_cfg_r[SENSE_BIT];
  wire test_mode = ref_cfg_r[TEST_BIT];
  wire [MAIN_W-1:0] main_count = fb_cfg_r[MAIN_LSB +: MAIN_W];
  wire [SWALLOW_W-1:0] swallow_count = fb_cfg_r[SWALLOW_LSB +: SWALLOW_W];
  wire [CTL_W-1:0] control_pair = fb_cfg_r[CTL_LSB +: CTL_W];
  wire [RATIO_W-1:0] ref_last = ref_ratio - RATIO_ONE;
  wire [MAIN_W-1:0] main_last = main_count - MAIN_ONE;

  // ------------------------------------------------------------
  // power control
  // ------------------------------------------------------------
  logic sleep_r, up_r, dn_r, sleep_nxt;
  wire ctl_async = (control_pair == CTL_ASYNC_SLEEP);
  wire ctl_sync = (control_pair == CTL_SYNC_SLEEP);
  wire ctl_clear = (control_pair == CTL_CLEAR);
  wire pump_idle = ~up_r & ~dn_r;

  // sync sleep waits for the pump pulse in flight to end; async does not
  always_comb begin
    if (!ce_lvl || ctl_async) begin
      sleep_nxt = 1'b1;
    end else if (ctl_sync) begin
      sleep_nxt = sleep_r | pump_idle;
    end else begin
      sleep_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sleep_r <= 1'b0;
    end else begin
      sleep_r <= sleep_nxt;
    end
  end

  // counters sit at load point while asleep or cleared
  wire div_hold = sleep_r | (ce_lvl & ctl_clear);
  assign sleep_status = sleep_r;
  assign ref_osc_en = ~sleep_r;
  assign rf_bias_en = ~sleep_r;

  // ------------------------------------------------------------
  // reference divider
  // ------------------------------------------------------------
  logic [RATIO_W-1:0] ref_cnt_r;
  logic fr_pulse_r;

  // counts reference input edges; both counters restart from zero together
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ref_cnt_r <= RATIO_ZERO;
      fr_pulse_r <= 1'b0;
    end else if (div_hold) begin
      ref_cnt_r <= RATIO_ZERO;
      fr_pulse_r <= 1'b0;
    end else begin
      fr_pulse_r <= 1'b0;
      if (ref_rise) begin
        if (ref_cnt_r >= ref_last) begin
          ref_cnt_r <= RATIO_ZERO;
          fr_pulse_r <= 1'b1;
        end else begin
          ref_cnt_r <= ref_cnt_r + RATIO_ONE;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // feedback divider
  // ------------------------------------------------------------
  logic [MAIN_W-1:0] fb_cnt_r;
  logic fn_pulse_r;
  logic swallow_on;

  // the first swallow_count prescaler cycles of each period use 33
  assign swallow_on = (fb_cnt_r < MAIN_W'(swallow_count)) & ~div_hold;
  assign modulus_sel = swallow_on;

  // one count per prescaler output edge: N = 32*main + swallow
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fb_cnt_r <= MAIN_ZERO;
      fn_pulse_r <= 1'b0;
    end else if (div_hold) begin
      fb_cnt_r <= MAIN_ZERO;
      fn_pulse_r <= 1'b0;
    end else begin
      fn_pulse_r <= 1'b0;
      if (rf_rise) begin
        if (fb_cnt_r >= main_last) begin
          fb_cnt_r <= MAIN_ZERO;
          fn_pulse_r <= 1'b1;
        end else begin
          fb_cnt_r <= fb_cnt_r + MAIN_ONE;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // phase/frequency detector
  // ------------------------------------------------------------
  // a float, sleep or chip disable parks the comparator; sleep or chip disable parks the pump too, a float only outside test mode
  wire pfd_off = pump_float | sleep_r | ~ce_lvl;
  wire both_set = (up_r | fr_pulse_r) & (dn_r | fn_pulse_r);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      up_r <= 1'b0;
      dn_r <= 1'b0;
    end else if (pfd_off || both_set) begin
      up_r <= 1'b0;
      dn_r <= 1'b0;
    end else begin
      up_r <= up_r | fr_pulse_r;
      dn_r <= dn_r | fn_pulse_r;
    end
  end

  // ------------------------------------------------------------
  // pump pin
  // ------------------------------------------------------------
  logic pump_out_r;
  logic pump_oe_r;
  wire drive_up = sense_pos ? up_r : dn_r;
  wire drive_dn = sense_pos ? dn_r : up_r;
  wire test_sig = sense_pos ? fn_pulse_r : fr_pulse_r;
  wire test_on = test_mode & ~sleep_r & ce_lvl;

  // test output beats the float bit, which the host sets alongside it
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pump_out_r <= 1'b0;
      pump_oe_r <= 1'b0;
    end else if (test_on) begin
      pump_out_r <= test_sig;
      pump_oe_r <= 1'b1;
    end else begin
      pump_out_r <= drive_up;
      pump_oe_r <= (drive_up | drive_dn) & ~pfd_off;
    end
  end

  // raw pin gate: chip disable floats the pump with no clock involved
  assign pump_output = pump_out_r;
  assign pump_output_oe = pump_oe_r & chip_enable;
  assign feedback_divider_config = fb_cfg_r;
  assign reference_divider_config = ref_cfg_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_ref_lead;
    fr_pulse_r && !fn_pulse_r && !dn_r && !pfd_off;
  endsequence
  sequence s_up_drive;
    up_r && !dn_r;
  endsequence

  a_load_ref_word: assert property (
    load_ref |=> ref_cfg_r == $past(sr_data[REF_W-1:0]))
    else $error("reference word not latched");
  a_load_fb_word: assert property (
    load_fb |=> fb_cfg_r == $past(sr_data) && $stable(ref_cfg_r))
    else $error("feedback word not latched");
  a_cfg_hold_quiet: assert property (
    !strobe_rise |=> $stable(ref_cfg_r) && $stable(fb_cfg_r))
    else $error("register changed without strobe");
  a_ref_wrap_pulse: assert property (
    ref_rise && !div_hold && ref_cnt_r == ref_last && ref_ratio >= 2
    |=> fr_pulse_r && ref_cnt_r == RATIO_ZERO)
    else $error("reference divider wrap wrong");
  a_hold_load_point: assert property (
    div_hold |=> ref_cnt_r == RATIO_ZERO && fb_cnt_r == MAIN_ZERO && !fn_pulse_r)
    else $error("dividers not at load point");
  a_modulus_choice: assert property (
    !div_hold |-> modulus_sel == (fb_cnt_r < MAIN_W'(swallow_count)))
    else $error("prescaler modulus wrong");
  a_float_no_drive: assert property (
    pump_float && !test_mode |=> !pump_output_oe && !up_r && !dn_r)
    else $error("pump drives while floated");
  a_ce_low_float: assert property (
    !chip_enable |-> !pump_output_oe)
    else $error("pump drives with chip disabled");
  a_async_sleep_go: assert property (
    ce_lvl && ctl_async |=> sleep_r && !ref_osc_en && !rf_bias_en)
    else $error("async sleep not immediate");
  a_sync_sleep_wait: assert property (
    $rose(sleep_r) && $past(ce_lvl) && $past(ctl_sync) |-> $past(pump_idle))
    else $error("sync sleep cut a pump pulse");
  a_ref_lead_up: assert property (
    s_ref_lead |=> s_up_drive)
    else $error("reference lead gave no up drive");
  a_sense_swap: assert property (
    (s_up_drive and (!pfd_off && !test_on && !sense_pos))
    |=> pump_oe_r && !pump_out_r)
    else $error("negative sense did not swap");
  a_test_route: assert property (
    test_on |=> pump_oe_r && pump_out_r == $past(test_sig))
    else $error("test mode output wrong");

endmodule

`default_nettype wire

// File: psd_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// host driving the three-wire link
// ------------------------------------------------------------
module psd_host_model (
  output logic ser_clk,
  output logic ser_data,
  output logic latch_strobe
);
  // link clock rests low outside frames, 12 ns period inside them
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    latch_strobe = 1'b0;
  end

  // one frame; strobe optional so a frame can be shifted without loading
  task automatic send_word(input logic [16:0] data, input logic addr, input logic strobe);
    logic [17:0] w;
    w = {data, addr};
    #3;
    for (int i = 17; i >= 0; i--) begin
      ser_data = w[i];
      #6 ser_clk = 1'b1;
      #6 ser_clk = 1'b0;
    end
    // no pull on the data line, so show the inverse rather than a stale bit
    ser_data = ~w[0];
    #20 latch_strobe = strobe;
    #60 latch_strobe = 1'b0;
    #80;
  endtask

  // reserved bit always zero, float bit forced with the test bit
  task automatic write_ref(input logic [9:0] ra, input logic fl, input logic se, input logic te);
    send_word({3'h0, te, 1'b0, se, fl | te, ra}, 1'b1, 1'b1);
  endtask

  // callers keep main at least 3 and not below swallow
  task automatic write_fb(input logic [9:0] mn, input logic [4:0] sw, input logic [1:0] ctl);
    send_word({mn, sw, ctl}, 1'b0, 1'b1);
  endtask
endmodule

`default_nettype wire

// File: psd_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// testbench top
// ------------------------------------------------------------
module psd_top_tb_top;
  import psd_pkg::*;
  logic clk_sys, arst_n, chip_enable, reference_input, rf_input;
  wire logic ser_clk, ser_data, latch_strobe;
  logic modulus_sel, pump_output, pump_output_oe, ref_osc_en, rf_bias_en, sleep_status;
  logic [FB_W-1:0] feedback_divider_config;
  logic [REF_W-1:0] reference_divider_config;
  logic [16:0] e_ref, e_fb;
  logic [31:0] r;
  logic counting;
  int failures, checks, pulses;
  integer seed;

  psd_top i_psd_top (
    .clk_sys(clk_sys), .arst_n(arst_n), .ser_clk(ser_clk), .ser_data(ser_data),
    .latch_strobe(latch_strobe), .chip_enable(chip_enable),
    .reference_input(reference_input), .rf_input(rf_input), .modulus_sel(modulus_sel),
    .pump_output(pump_output), .pump_output_oe(pump_output_oe), .ref_osc_en(ref_osc_en),
    .rf_bias_en(rf_bias_en), .sleep_status(sleep_status),
    .feedback_divider_config(feedback_divider_config),
    .reference_divider_config(reference_divider_config)
  );

  psd_host_model i_host (.ser_clk(ser_clk), .ser_data(ser_data), .latch_strobe(latch_strobe));

  // system clock, 100 MHz
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // counts driven one-cycle divider pulses on the pump pin
  always @(posedge clk_sys) begin
    if (counting && pump_output === 1'b1 && pump_output_oe === 1'b1) pulses++;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // inputs set right after this task move 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // slow edges so the three-stage synchronisers never miss one
  task automatic edges(input logic on_ref, input int n);
    repeat (n) begin
      if (on_ref) reference_input = 1'b1;
      else rf_input = 1'b1;
      cyc(4);
      reference_input = 1'b0;
      rf_input = 1'b0;
      cyc(4);
    end
  endtask

  // bounded wait; running out counts as a mismatch and ends the run
  task automatic expect_within(input string what, ref logic sig, input logic val, input int n);
    int k;
    k = 0;
    while (sig !== val && k < n) begin
      cyc(1);
      k++;
    end
    chk(what, 17'(val), 17'(sig));
    if (sig !== val) give_verdict();
  endtask

  // expected reference word: reserved bit zero, float forced along with test
  function automatic logic [16:0] ref_word(input logic [9:0] ra, input logic fl,
      input logic se, input logic te);
    return {3'h0, te, 1'b0, se, fl | te, ra};
  endfunction

  task automatic wr_ref(input logic [9:0] ra, input logic fl, input logic se, input logic te);
    e_ref = ref_word(ra, fl, se, te);
    i_host.write_ref(ra, fl, se, te);
    chk("reference config", e_ref, {3'h0, reference_divider_config});
    chk("feedback config kept", e_fb, feedback_divider_config);
  endtask

  task automatic wr_fb(input logic [9:0] mn, input logic [4:0] sw, input logic [1:0] ctl);
    e_fb = {mn, sw, ctl};
    i_host.write_fb(mn, sw, ctl);
    chk("feedback config", e_fb, feedback_divider_config);
    chk("reference config kept", e_ref, {3'h0, reference_divider_config});
  endtask

  // hang guard
  initial begin
    #200000;
    failures++;
    give_verdict();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'he23f3b00;
    failures = 0;
    checks = 0;
    pulses = 0;
    counting = 1'b0;
    arst_n = 1'b0;
    chip_enable = 1'b1;
    reference_input = 1'b0;
    rf_input = 1'b0;
    e_ref = 17'h00000;
    e_fb = 17'h00000;
    cyc(12);
    arst_n = 1'b1;
    cyc(2);
    // a frame shifted without a strobe must not load anything
    i_host.send_word(17'h1ffff, 1'b1, 1'b0);
    chk("reference after shift", e_ref, {3'h0, reference_divider_config});
    // random writes to both registers, the other one must stay put
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      if (r[31]) wr_ref(10'(2 + r[9:0] % 1022), r[10], r[11], 1'b0);
      else wr_fb(10'(31 + r[9:0] % 993), r[14:10], r[16:15]);
    end
    // detector drive for both sense settings, dividers cleared first
    for (int s = 0; s < 2; s++) begin
      wr_fb(10'h003, 5'h00, CTL_CLEAR);
      wr_ref(10'h002, 1'b0, s[0], 1'b0);
      wr_fb(10'h003, 5'h00, CTL_RUN);
      edges(1'b1, 2);
      expect_within("pump drive", pump_output_oe, 1'b1, 10);
      chk("pump sense", 17'(s[0]), 17'(pump_output));
      edges(1'b0, 3);
      expect_within("pump release", pump_output_oe, 1'b0, 10);
    end
    // float bit keeps the pump off even with reference edges pending
    wr_ref(10'h002, 1'b1, 1'b1, 1'b0);
    edges(1'b1, 4);
    chk("pump floated", 17'h0, 17'(pump_output_oe));
    // test mode: six edges into a divide-by-three give two pulses
    for (int s = 0; s < 2; s++) begin
      wr_fb(10'h003, 5'h00, CTL_CLEAR);
      wr_ref(10'h003, 1'b1, s[0], 1'b1);
      wr_fb(10'h003, 5'h00, CTL_RUN);
      pulses = 0;
      counting = 1'b1;
      edges(~s[0], 6);
      counting = 1'b0;
      chk("test pulses", 17'h2, 17'(pulses));
    end
    // held at load point the prescaler modulus rests; on restart 33 comes first
    wr_fb(10'h005, 5'h03, CTL_CLEAR);
    chk("modulus at load point", 17'h0, 17'(modulus_sel));
    wr_fb(10'h005, 5'h03, CTL_RUN);
    chk("modulus after restart", 17'h1, 17'(modulus_sel));
    wr_ref(10'h002, 1'b0, 1'b1, 1'b0);
    wr_fb(10'h003, 5'h00, CTL_ASYNC_SLEEP);
    chk("async asleep", 17'h1, 17'(sleep_status));
    chk("oscillator and bias off", 17'h0, 17'({ref_osc_en, rf_bias_en}));
    wr_ref(10'h155, 1'b0, 1'b1, 1'b0);
    wr_ref(10'h002, 1'b0, 1'b1, 1'b0);
    edges(1'b1, 4);
    chk("pump off asleep", 17'h0, 17'(pump_output_oe));
    wr_fb(10'h003, 5'h00, CTL_RUN);
    chk("awake", 17'h0, 17'(sleep_status));
    wr_fb(10'h003, 5'h00, CTL_SYNC_SLEEP);
    chk("sync asleep", 17'h1, 17'(sleep_status));
    wr_fb(10'h003, 5'h00, CTL_RUN);
    // chip enable low cuts a driving pump at once, then sleeps
    edges(1'b1, 2);
    expect_within("pump drive again", pump_output_oe, 1'b1, 10);
    chip_enable = 1'b0;
    #1;
    chk("pump off chip disabled", 17'h0, 17'(pump_output_oe));
    expect_within("chip disabled asleep", sleep_status, 1'b1, 10);
    cyc(1);
    chip_enable = 1'b1;
    expect_within("chip enabled awake", sleep_status, 1'b0, 10);
    give_verdict();
  end
endmodule

`default_nettype wire
